//--- pdpm_pkg.sv
// Package of constants and types for the power-state and thermal manager
package pdpm_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned IDLE_TIME_US = 1000;
   localparam int unsigned IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
   localparam int unsigned BOOT_TIME_US = 100;
   localparam int unsigned BOOT_CYCLES = BOOT_TIME_US * CLK_MHZ;

   // ---------------------------------------------------------------
   // Boot sources and addresses
   // ---------------------------------------------------------------
   localparam logic [6:0] EEPROM_ADDR = 7'h50;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PDPM_ACTIVE,
      PDPM_IDLE,
      PDPM_SLEEP
   } pdpm_state_t;

   typedef enum logic [1:0] {
      PDPM_BOOT_WAIT,
      PDPM_BOOT_EEPROM,
      PDPM_BOOT_HOST,
      PDPM_BOOT_DONE
   } pdpm_boot_t;

endpackage : pdpm_pkg

//--- pdpm_sync.sv
// Three-flop synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/10ps
module pdpm_sync #(
   parameter int unsigned W = 1
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] level_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // Chain; first stage feeds only the second
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a change only when stages two and three agree
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_o <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               level_o[i] <= s2_q[i];
            end
         end
      end
   end
endmodule // pdpm_sync

//--- pdpm_manager.sv
// Power-state and thermal-protection manager, top level
// Contract
// - Always exactly one of active, idle or sleep.
// - Standby is a flavour of idle, not a fourth state.
// - State changes happen autonomously from circuit activity.
// - Attach detection keeps running while asleep.
// - Active to idle only after a full quiet interval.
// - Die over-temperature disables all but supervisory logic.
// - Resume after die shutdown only below threshold minus hysteresis.
// - Either path over-temperature kills both sources and cable supply.
// - After path cool-down resume automatically or wait for firmware.
// - Configuration bundle loads from host port or EEPROM.
// - Host port configures and controls every option; the code takes only the bundle load and path re-enable from the host side.
`timescale 1ns/10ps
module pdpm_manager #(
   parameter int unsigned IDLE_CYC = pdpm_pkg::IDLE_CYCLES,
   parameter int unsigned BOOT_CYC = pdpm_pkg::BOOT_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic pd_msg_i,
   input wire logic cc_change_i,
   input wire logic gpio_event_i,
   input wire logic i2c_txn_i,
   input wire logic volt_alert_i,
   input wire logic fault_alert_i,
   input wire logic attach_i,
   input wire logic standby_req_i,
   input wire logic sleep_req_i,
   input wire logic source_role_i,
   input wire logic die_hot_i,
   input wire logic die_cool_i,
   input wire logic path_hot_i,
   input wire logic path_cool_i,
   input wire logic path_auto_resume_i,
   input wire logic path_reenable_i,
   input wire logic eeprom_present_i,
   input wire logic eeprom_load_done_i,
   input wire logic host_load_done_i,
   output logic [1:0] power_state_o,
   output logic standby_o,
   output logic func_enable_o,
   output logic attach_detect_en_o,
   output logic port1_source_switch_o,
   output logic port2_source_switch_o,
   output logic port1_sink_gate_ctrl_o,
   output logic port2_sink_gate_ctrl_o,
   output logic port1_cable_supply_switch_o,
   output logic port2_cable_supply_switch_o,
   output logic die_shutdown_o,
   output logic path_shutdown_o,
   output logic eeprom_read_o,
   output logic [6:0] eeprom_addr_o,
   output logic config_loaded_o
);
   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   localparam int unsigned NIN = 19;
   logic [NIN-1:0] raw;
   logic [NIN-1:0] syn;
   logic act_any;
   logic die_hot, die_cool, path_hot, path_cool, auto_res, reen;
   logic attach, stby_req, slp_req, src_role, ee_pres, ee_done, host_done;

   assign raw = {pd_msg_i, cc_change_i, gpio_event_i, i2c_txn_i,
                 volt_alert_i, fault_alert_i, attach_i, standby_req_i,
                 sleep_req_i, source_role_i, die_hot_i, die_cool_i,
                 path_hot_i, path_cool_i, path_auto_resume_i,
                 path_reenable_i, eeprom_present_i, eeprom_load_done_i,
                 host_load_done_i};

   pdpm_sync #(.W(NIN)) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .async_i(raw),
      .level_o(syn)
   );

   // Activity sources; any level restarts the quiet timer
   assign act_any = |syn[18:13];
   assign {attach, stby_req, slp_req, src_role, die_hot, die_cool, path_hot,
           path_cool, auto_res, reen, ee_pres, ee_done, host_done} =
          syn[12:0];

   // ---------------------------------------------------------------
   // Thermal protection
   // ---------------------------------------------------------------
   logic die_sd_q, path_sd_q;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         die_sd_q <= 1'b0;
      end else if (die_hot) begin
         die_sd_q <= 1'b1;
      end else if (die_cool) begin
         die_sd_q <= 1'b0; // Cool flag means below threshold minus hyst
      end
   end

   // Path shutdown, auto or firmware release
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         path_sd_q <= 1'b0;
      end else if (path_hot) begin
         path_sd_q <= 1'b1; // Set wins over any release
      end else if (path_cool && (auto_res || reen)) begin
         path_sd_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Boot configuration load
   // ---------------------------------------------------------------
   pdpm_pkg::pdpm_boot_t boot_q;
   logic [31:0] boot_cnt_q;

   // EEPROM first, otherwise wait on host port
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         boot_q <= pdpm_pkg::PDPM_BOOT_WAIT;
         boot_cnt_q <= '0;
      end else begin
         unique case (boot_q)
            pdpm_pkg::PDPM_BOOT_WAIT: begin
               if (boot_cnt_q >= BOOT_CYC - 1) begin
                  boot_q <= ee_pres ? pdpm_pkg::PDPM_BOOT_EEPROM
                                    : pdpm_pkg::PDPM_BOOT_HOST;
               end else begin
                  boot_cnt_q <= boot_cnt_q + 32'h1;
               end
            end
            pdpm_pkg::PDPM_BOOT_EEPROM: begin
               if (ee_done) begin
                  boot_q <= pdpm_pkg::PDPM_BOOT_DONE;
               end
            end
            // Host port loads the bundle; later it drives only the path re-enable
            pdpm_pkg::PDPM_BOOT_HOST: begin
               if (host_done) begin
                  boot_q <= pdpm_pkg::PDPM_BOOT_DONE;
               end
            end
            pdpm_pkg::PDPM_BOOT_DONE: begin
               boot_q <= pdpm_pkg::PDPM_BOOT_DONE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Power-state machine
   // ---------------------------------------------------------------
   pdpm_pkg::pdpm_state_t st_q;
   logic [31:0] quiet_q;

   // Quiet interval, restarted by any activity
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         quiet_q <= '0;
      end else if (act_any || st_q != pdpm_pkg::PDPM_ACTIVE) begin
         quiet_q <= '0;
      end else if (quiet_q < IDLE_CYC) begin
         quiet_q <= quiet_q + 32'h1;
      end
   end

   // Autonomous moves among three states only
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= pdpm_pkg::PDPM_ACTIVE;
      end else begin
         unique case (st_q)
            pdpm_pkg::PDPM_ACTIVE: begin
               if (!act_any && quiet_q >= IDLE_CYC - 1) begin
                  st_q <= pdpm_pkg::PDPM_IDLE;
               end
            end
            pdpm_pkg::PDPM_IDLE: begin
               if (act_any) begin
                  st_q <= pdpm_pkg::PDPM_ACTIVE;
               end else if (slp_req && !attach) begin
                  st_q <= pdpm_pkg::PDPM_SLEEP;
               end
            end
            // Attach still wakes the device from sleep
            pdpm_pkg::PDPM_SLEEP: begin
               if (attach || act_any) begin
                  st_q <= pdpm_pkg::PDPM_ACTIVE;
               end
            end
            default: begin
               st_q <= pdpm_pkg::PDPM_ACTIVE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   logic idle_w, act_w, stby_w, paths_ok;
   assign act_w = (st_q == pdpm_pkg::PDPM_ACTIVE);
   assign idle_w = (st_q == pdpm_pkg::PDPM_IDLE);
   assign stby_w = idle_w && stby_req;
   // No source or cable enable while any shutdown stands; sink gates see only die shutdown
   assign paths_ok = !die_sd_q && !path_sd_q &&
                     (boot_q == pdpm_pkg::PDPM_BOOT_DONE);

   // Switch map by state, role and standby
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         port1_source_switch_o <= 1'b0;
         port2_source_switch_o <= 1'b0;
         port1_sink_gate_ctrl_o <= 1'b0;
         port2_sink_gate_ctrl_o <= 1'b0;
         port1_cable_supply_switch_o <= 1'b0;
         port2_cable_supply_switch_o <= 1'b0;
      end else begin
         port1_source_switch_o <= paths_ok && src_role && (act_w || idle_w);
         port2_source_switch_o <= paths_ok && src_role && (act_w ||
                                  (idle_w && !stby_w));
         port1_sink_gate_ctrl_o <= !die_sd_q && !src_role &&
                                   (act_w || (idle_w && !stby_w));
         port2_sink_gate_ctrl_o <= !die_sd_q && !src_role &&
                                   (act_w || (idle_w && !stby_w));
         port1_cable_supply_switch_o <= paths_ok &&
                                        (act_w || (idle_w && !stby_w));
         port2_cable_supply_switch_o <= paths_ok &&
                                        (act_w || (idle_w && !stby_w));
      end
   end

   // Status and boot outputs
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power_state_o <= 2'h0;
         standby_o <= 1'b0;
         func_enable_o <= 1'b0;
         attach_detect_en_o <= 1'b1;
         die_shutdown_o <= 1'b0;
         path_shutdown_o <= 1'b0;
         eeprom_read_o <= 1'b0;
         eeprom_addr_o <= 7'h00;
         config_loaded_o <= 1'b0;
      end else begin
         power_state_o <= st_q;
         standby_o <= stby_w;
         func_enable_o <= !die_sd_q;
         attach_detect_en_o <= 1'b1; // Supervisory, never gated
         die_shutdown_o <= die_sd_q;
         path_shutdown_o <= path_sd_q;
         eeprom_read_o <= (boot_q == pdpm_pkg::PDPM_BOOT_EEPROM);
         eeprom_addr_o <= pdpm_pkg::EEPROM_ADDR;
         config_loaded_o <= (boot_q == pdpm_pkg::PDPM_BOOT_DONE);
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   one_state_a: assert property (st_q inside {pdpm_pkg::PDPM_ACTIVE,
      pdpm_pkg::PDPM_IDLE, pdpm_pkg::PDPM_SLEEP})
      else $error("power state illegal");
   stby_idle_a: assert property (standby_o |-> power_state_o == 2'h1)
      else $error("standby outside idle");
   quiet_idle_a: assert property ($rose(idle_w) && $past(act_w)
      |-> $past(quiet_q) >= IDLE_CYC - 1)
      else $error("idle before quiet interval");
   wake_sleep_a: assert property (st_q == pdpm_pkg::PDPM_SLEEP && attach
      |=> act_w) else $error("attach missed in sleep");
   die_off_a: assert property (die_sd_q |=> !func_enable_o)
      else $error("functions alive in die shutdown");
   die_hold_a: assert property (die_sd_q && !die_cool |=> die_sd_q)
      else $error("die shutdown left early");
   path_off_a: assert property (path_sd_q |=> !port1_source_switch_o &&
      !port2_source_switch_o && !port1_cable_supply_switch_o &&
      !port2_cable_supply_switch_o) else $error("path on in shutdown");
   path_rel_a: assert property ($fell(path_sd_q)
      |-> $past(path_cool) && ($past(auto_res) || $past(reen)))
      else $error("path released without cause");
   sleep_off_a: assert property (st_q == pdpm_pkg::PDPM_SLEEP
      |=> !port1_source_switch_o && !port1_sink_gate_ctrl_o)
      else $error("switch on in sleep");
   boot_gate_a: assert property (port1_source_switch_o
      |-> config_loaded_o || boot_q == pdpm_pkg::PDPM_BOOT_DONE)
      else $error("switch before configuration");

   idle_c: cover property (act_w ##1 idle_w);
   sleep_c: cover property (idle_w ##1 st_q == pdpm_pkg::PDPM_SLEEP);
   die_c: cover property ($rose(die_sd_q));
   path_c: cover property ($fell(path_sd_q));
endmodule // pdpm_manager

//--- pdpm_ec_model.sv
// Embedded controller model on the host side of the manager
`timescale 1ns/10ps
module pdpm_ec_model #(
   parameter int unsigned LOAD_CYC = 12
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic load_req_i,
   input wire logic reenable_req_i,
   output logic i2c_txn_o,
   output logic host_load_done_o,
   output logic path_reenable_o
);
   int unsigned cnt_q;

   // -------------------------------------------------------------
   // Bundle download
   // -------------------------------------------------------------
   // host bundle load
   // Port busy for the transfer, then done; bytes are abstracted
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 0;
         i2c_txn_o <= 1'b0;
         host_load_done_o <= 1'b0;
      end else if (load_req_i && !host_load_done_o) begin
         cnt_q <= cnt_q + 1;
         i2c_txn_o <= (cnt_q < LOAD_CYC);
         host_load_done_o <= (cnt_q == LOAD_CYC);
      end else begin
         i2c_txn_o <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Firmware control
   // -------------------------------------------------------------
   // host control path
   // Re-enable command held as a level until withdrawn
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         path_reenable_o <= 1'b0;
      end else begin
         path_reenable_o <= reenable_req_i;
      end
   end
endmodule // pdpm_ec_model

//--- pdpm_manager_bench.sv
// Self-checking bench for the power-state and thermal manager
`timescale 1ns/10ps
module pdpm_manager_bench;
   logic mclk_i, rst_n_i, attach, stby, slp, role, dhot, dcool, phot;
   logic pcool, pauto, eep, eep_done, load_req, ren_req, ec_txn, h_done;
   logic p_ren;
   logic [5:0] act, sw;
   logic [1:0] ps;
   logic stby_o, func_en, att_en, s1, s2, k1, k2, c1, c2, die_sd, path_sd;
   logic eep_rd, cfg_ok;
   logic [6:0] eep_addr;
   int err_total, n_tests, k, r;

   // -------------------------------------------------------------
   // Design, partner and clock
   // -------------------------------------------------------------
   pdpm_manager #(.IDLE_CYC(20), .BOOT_CYC(10)) dut (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .pd_msg_i(act[0]), .cc_change_i(act[1]),
      .gpio_event_i(act[2]), .i2c_txn_i(act[3] | ec_txn),
      .volt_alert_i(act[4]), .fault_alert_i(act[5]), .attach_i(attach),
      .standby_req_i(stby), .sleep_req_i(slp), .source_role_i(role),
      .die_hot_i(dhot), .die_cool_i(dcool), .path_hot_i(phot),
      .path_cool_i(pcool), .path_auto_resume_i(pauto),
      .path_reenable_i(p_ren), .eeprom_present_i(eep),
      .eeprom_load_done_i(eep_done), .host_load_done_i(h_done),
      .power_state_o(ps), .standby_o(stby_o), .func_enable_o(func_en),
      .attach_detect_en_o(att_en), .port1_source_switch_o(s1),
      .port2_source_switch_o(s2), .port1_sink_gate_ctrl_o(k1),
      .port2_sink_gate_ctrl_o(k2), .port1_cable_supply_switch_o(c1),
      .port2_cable_supply_switch_o(c2), .die_shutdown_o(die_sd),
      .path_shutdown_o(path_sd), .eeprom_read_o(eep_rd),
      .eeprom_addr_o(eep_addr), .config_loaded_o(cfg_ok));
   pdpm_ec_model ec (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .load_req_i(load_req), .reenable_req_i(ren_req), .i2c_txn_o(ec_txn),
      .host_load_done_o(h_done), .path_reenable_o(p_ren));
   // Switch enables gathered for one compare
   assign sw = {s1, s2, k1, k2, c1, c2};
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic give_verdict();
      $display("mismatches %0d of %0d checks", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                      input string msg);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask
   // Inputs change 1 ns after the edge, never on it
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   function automatic logic [1:0] pick(input int sel);
      case (sel)
         0: return ps;
         1: return {1'b0, die_sd};
         2: return {1'b0, path_sd};
         3: return {1'b0, cfg_ok};
         default: return {1'b0, eep_rd};
      endcase
   endfunction
   // Bounded wait; running out ends the run as a failure
   task automatic wait_for(input int sel, input logic [1:0] v, input int lim);
      int i;
      i = 0;
      while (pick(sel) !== v && i < lim) begin
         tick(1);
         i++;
      end
      if (pick(sel) !== v) begin
         err_total++;
         $display("CHECK FAILED t=%0t wait %0d timed out", $time, sel);
         give_verdict();
      end
   endtask
   task automatic do_reset();
      rst_n_i = 1'b0;
      tick(6);
      rst_n_i = 1'b1;
   endtask
   // Held three cycles so the input filter sees it
   task automatic pulse_act(input int b);
      act[b] = 1'b1;
      tick(3);
      act[b] = 1'b0;
   endtask
   task automatic wake();
      attach = 1'b1;
      act[0] = 1'b1;
      tick(3);
      attach = 1'b0;
      act[0] = 1'b0;
      wait_for(0, 2'h0, 20);
      tick(2);
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_boot();
      wait_for(4, 2'h1, 60);
      chk({1'b0, eep_addr}, 8'h50, "eeprom address");
      chk({2'h0, sw}, 8'h00, "switches before load");
      eep_done = 1'b1;
      wait_for(3, 2'h1, 40);
      chk({7'h0, att_en}, 8'h01, "attach detect");
      eep = 1'b0;
      eep_done = 1'b0;
      do_reset();
      load_req = 1'b1;
      wait_for(3, 2'h1, 200);
      chk({7'h0, eep_rd}, 8'h00, "host boot read eeprom");
   endtask
   task automatic t_idle();
      for (k = 0; k < 6; k++) begin
         wake();
         pulse_act(k);
         tick(12);
         chk({6'h0, ps}, 8'h00, "early idle");
         pulse_act(k);
         tick(12);
         chk({6'h0, ps}, 8'h00, "timer not restarted");
         wait_for(0, 2'h1, 40);
      end
   endtask
   task automatic t_switch();
      for (r = 0; r < 2; r++) begin
         role = (r == 0);
         tick(8);
         wake();
         chk({2'h0, sw}, role ? 8'h33 : 8'h0f, "active switches");
         wait_for(0, 2'h1, 40);
         tick(2);
         chk({2'h0, sw}, role ? 8'h33 : 8'h0f, "idle switches");
         stby = 1'b1;
         tick(8);
         chk({5'h0, stby_o, ps}, 8'h05, "standby in idle");
         chk({2'h0, sw}, role ? 8'h20 : 8'h00, "standby sw");
         stby = 1'b0;
         slp = 1'b1;
         wait_for(0, 2'h2, 40);
         tick(2);
         chk({1'b0, att_en, sw}, 8'h40, "sleep outputs");
         slp = 1'b0;
         wake();
      end
   endtask
   task automatic t_die();
      role = 1'b1; // Source map expected on resume and in the path test
      dcool = 1'b0;
      dhot = 1'b1;
      wait_for(1, 2'h1, 20);
      tick(2);
      chk({1'b0, func_en, sw}, 8'h00, "die shutdown");
      dhot = 1'b0;
      tick(10);
      chk({7'h0, die_sd}, 8'h01, "inside hysteresis");
      wake();
      chk({2'h0, sw}, 8'h00, "enable while hot");
      dcool = 1'b1;
      wait_for(1, 2'h0, 20);
      tick(2);
      chk({1'b0, func_en, sw}, 8'h73, "die resume");
   endtask
   task automatic t_path();
      for (r = 0; r < 2; r++) begin
         pauto = (r == 1);
         pcool = 1'b0;
         phot = 1'b1;
         wait_for(2, 2'h1, 20);
         tick(2);
         chk({2'h0, sw}, 8'h00, "path shutdown");
         phot = 1'b0;
         pcool = 1'b1;
         tick(10);
         chk({7'h0, path_sd}, {7'h0, ~pauto}, "cool release");
         ren_req = 1'b1;
         wait_for(2, 2'h0, 20);
         ren_req = 1'b0;
         tick(2);
         chk({2'h0, sw}, 8'h33, "path resume");
      end
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      err_total = 0;
      n_tests = 0;
      rst_n_i = 1'b0;
      {act, attach, stby, slp, dhot, phot, pauto} = '0;
      {eep_done, load_req, ren_req} = '0;
      {role, dcool, pcool, eep} = 4'hf;
      do_reset();
      t_boot();
      t_idle();
      t_switch();
      t_die();
      t_path();
      give_verdict();
   end
endmodule // pdpm_manager_bench
